// ===== pcmc_pkg.sv
package pcmc_pkg;
  localparam int CORE_PERIOD_NS = 50;
  localparam int RX_HALF_CYCLES = 2;
  localparam int CM_SETTLE_NS = 1000;
  localparam int CM_SETTLE_CYCLES = (CM_SETTLE_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int DETECT_NS = 2000;
  localparam int DETECT_CYCLES = (DETECT_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int MOVE_NS = 200;
  localparam int MOVE_CYCLES = (MOVE_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam logic [1:0] PS_FULL = 2'h0;
  localparam logic [1:0] PS_TX_STANDBY = 2'h1;
  localparam logic [1:0] PS_LINK_IDLE = 2'h2;
  localparam logic [1:0] PS_UNSUPPORTED = 2'h3;
  localparam logic [2:0] RXST_NONE = 3'h0;
  localparam logic [2:0] RXST_PRESENT = 3'h3;
  localparam logic [15:0] SCR_SEED = 16'hFFFF;
  localparam logic [15:0] SCR_TAPS = 16'h0039;
  localparam logic [7:0] REG_CTRL_OFS = 8'h00;
  localparam logic [7:0] REG_STATUS_OFS = 8'h04;
  localparam int CTRL_SCR_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h00000001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef struct packed {
    logic detect_present;
    logic rx_saving;
    logic rx_clk_stopped;
    logic ref_125;
    logic busy;
    logic [1:0] power_state;
  } pcmc_status_type;
endpackage : pcmc_pkg

// ===== pcmc_top.sv
// Contract
// - Wide mode: 16-bit words, rising edge only
// - Narrow mode: 8-bit bytes on both edges
// - Rx data on own clock, tx on MAC's
// - Device scrambles tx, descrambles rx data
// - Two-bit select picks three power states
// - Each transition ends with one-cycle done pulse
// - Parallel clock runs in all three states, but deep sleep stops it in link idle
// - Serial traffic only in full power
// - Line idle puts receiver into power saving in full power and tx standby
// - Link idle needs both channels idle; the sequencer enters it without checking tx or rx line idle
// - Link idle done waits for settled clock
// - Clock select sampled at reset release
// - Done drops after clock ran and state reached
// - Detect request in link idle starts detection
// - Detection done: pulse plus 000 or 011
`timescale 1ns/1ps
`default_nettype none
module pcmc_top
  import pcmc_pkg::*;
#(
  parameter int RX_HALF = RX_HALF_CYCLES
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic [7:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [7:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [1:0] I_POWER_STATE_SELECT,
  input wire logic I_DETECT_OR_LOOPBACK,
  input wire logic I_DEEP_SLEEP_REQUEST,
  input wire logic I_TX_ELECTRICAL_IDLE,
  input wire logic I_CLK_SEL,
  input wire logic I_NARROW_MODE,
  input wire logic I_TX_INPUT_CLOCK,
  input wire logic [15:0] I_TX_DATA_BUS,
  input wire logic [15:0] I_RX_LINE_WORD,
  input wire logic I_RX_LINE_IDLE,
  input wire logic I_FAR_RECEIVER_SENSE,
  output logic O_RX_OUTPUT_CLOCK,
  output logic [15:0] O_RX_DATA_BUS,
  output logic [2:0] O_RX_STATUS,
  output logic O_PHY_DONE,
  output logic [15:0] O_TX_LINE_WORD,
  output logic O_TX_LINE_VALID,
  output logic O_RX_SAVING,
  output logic O_REF_SEL_125
);
  // Divider counter is only eight bits wide
  if (RX_HALF < 1 || RX_HALF > 255) begin : g_bad_rx_half
    $error("RX_HALF out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts when 2 and 3 agree
  localparam int SW = 23;
  logic [SW-1:0] pin_raw, s1_q, s2_q, s3_q, filt_q, filt_d;
  assign pin_raw = {I_TX_DATA_BUS, I_NARROW_MODE, I_CLK_SEL, I_TX_INPUT_CLOCK,
                    I_TX_ELECTRICAL_IDLE, I_DEEP_SLEEP_REQUEST, I_DETECT_OR_LOOPBACK,
                    I_POWER_STATE_SELECT[1]};
  logic ps0_s1_q, ps0_s2_q, ps0_s3_q, ps0_f_q;
  assign filt_d = (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      filt_q <= '0;
      {ps0_s1_q, ps0_s2_q, ps0_s3_q, ps0_f_q} <= 4'h0;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
      {ps0_s1_q, ps0_s2_q, ps0_s3_q} <= {I_POWER_STATE_SELECT[0], ps0_s1_q, ps0_s2_q};
      ps0_f_q <= (ps0_s2_q == ps0_s3_q) ? ps0_s2_q : ps0_f_q;
    end
  end
  wire [1:0] req_ps = {filt_q[0], ps0_f_q};
  wire det_req = filt_q[1];
  wire sleep_req = filt_q[2];
  wire tx_idle = filt_q[3];
  wire tx_clk_lvl = filt_q[4];
  wire narrow = filt_q[6];
  wire [15:0] tx_word_in = s3_q[22:7];
  wire tx_rise = filt_d[4] & ~tx_clk_lvl;
  wire tx_fall = ~filt_d[4] & tx_clk_lvl;

  ////////////////////////////////////////////////////////////////////////
  // Register file over AXI4-Lite
  logic [31:0] ctrl_q;
  logic aw_got_q, w_got_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  pcmc_status_type status;
  wire aw_take = I_AWVALID & awready_q;
  wire w_take = I_WVALID & wready_q;
  wire aw_have = aw_got_q | aw_take;
  wire w_have = w_got_q | w_take;
  wire wr_go = aw_have & w_have & ~bvalid_q;
  wire [7:0] wr_addr = aw_take ? I_AWADDR : awaddr_q;
  wire [31:0] wr_data = w_take ? I_WDATA : wdata_q;
  wire [3:0] wr_strb = w_take ? I_WSTRB : wstrb_q;
  wire wr_ctrl = wr_go & (wr_addr == REG_CTRL_OFS);
  wire wr_hit = wr_ctrl | (wr_addr == REG_STATUS_OFS);
  wire bvalid_d = wr_go | (bvalid_q & ~I_BREADY);
  wire aw_got_d = aw_have & ~wr_go;
  wire w_got_d = w_have & ~wr_go;
  wire ar_take = I_ARVALID & arready_q;
  wire rvalid_d = ar_take | (rvalid_q & ~I_RREADY);
  wire rd_ctrl = I_ARADDR == REG_CTRL_OFS;
  wire rd_stat = I_ARADDR == REG_STATUS_OFS;
  wire [31:0] rd_mux = rd_ctrl ? ctrl_q : rd_stat ? {25'h0, status} : 32'h0;
  wire [31:0] ctrl_d = {ctrl_q[31:8], wr_strb[0] ? wr_data[7:0] : ctrl_q[7:0]} & CTRL_RESET;
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      {aw_got_q, w_got_q, bvalid_q, rvalid_q} <= 4'h0;
      {awready_q, wready_q, arready_q} <= 3'h7;
      {awaddr_q, wdata_q, wstrb_q, rdata_q} <= '0;
      {bresp_q, rresp_q} <= 4'h0;
      ctrl_q <= CTRL_RESET;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      bvalid_q <= bvalid_d;
      awready_q <= ~aw_got_d & ~bvalid_d;
      wready_q <= ~w_got_d & ~bvalid_d;
      if (aw_take) awaddr_q <= I_AWADDR;
      if (w_take) wdata_q <= I_WDATA;
      if (w_take) wstrb_q <= I_WSTRB;
      if (wr_go) bresp_q <= wr_hit ? RESP_OKAY : RESP_DECERR;
      if (wr_ctrl) ctrl_q <= ctrl_d;
      rvalid_q <= rvalid_d;
      arready_q <= ~rvalid_d;
      if (ar_take) rdata_q <= rd_mux;
      if (ar_take) rresp_q <= (rd_ctrl | rd_stat) ? RESP_OKAY : RESP_DECERR;
    end
  end
  wire scr_en = ctrl_q[CTRL_SCR_EN_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Receive clock: divided from the core clock, gated only by deep sleep
  typedef enum logic [1:0] {ST_BOOT, ST_RUN, ST_MOVE, ST_DETECT} pcmc_state_type;
  pcmc_state_type st_q, st_d;
  logic [1:0] cur_ps_q, tgt_ps_q;
  logic [7:0] div_q;
  logic rx_clk_q, ref_sel_q, caught_q;
  wire rx_stop = sleep_req & (cur_ps_q == PS_LINK_IDLE) & (st_q == ST_RUN);
  wire div_end = div_q == 8'(RX_HALF - 1);
  wire rx_tog = div_end & ~rx_stop;
  wire rx_rise = rx_tog & ~rx_clk_q;
  wire rx_fall = rx_tog & rx_clk_q;
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      div_q <= 8'h0;
      rx_clk_q <= 1'b0;
    end else begin
      div_q <= div_end ? 8'h0 : div_q + 8'h1;
      if (rx_tog) rx_clk_q <= ~rx_clk_q;
    end
  end
  // Strap caught on the first edge after release, never inside the reset
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      caught_q <= 1'b0;
      ref_sel_q <= 1'b0;
    end else if (!caught_q) begin
      caught_q <= 1'b1;
      ref_sel_q <= I_CLK_SEL;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power state and detection sequencer
  logic [15:0] cnt_q, cnt_d;
  logic [1:0] boot_rx_q;
  logic done_q, done_d, det_seen_q, present_q;
  logic [2:0] rxst_q, rxst_d;
  logic [1:0] cur_d, tgt_d;
  wire ps_legal = req_ps != PS_UNSUPPORTED;
  // Requests are taken only after the previous done pulse is over
  wire idle_ok = (st_q == ST_RUN) & ~done_q & ~sleep_req;
  wire det_go = idle_ok & det_req & ~det_seen_q & (cur_ps_q == PS_LINK_IDLE);
  wire move_go = idle_ok & ~det_req & ps_legal & (req_ps != cur_ps_q);
  always_comb begin
    st_d = st_q;
    cnt_d = (cnt_q != 16'h0) ? cnt_q - 16'h1 : cnt_q;
    done_d = (rx_rise & st_q != ST_BOOT) ? 1'b0 : done_q;
    rxst_d = (rx_rise & st_q != ST_BOOT) ? RXST_NONE : rxst_q;
    cur_d = cur_ps_q;
    tgt_d = tgt_ps_q;
    case (st_q)
      ST_BOOT: begin
        done_d = 1'b1;
        if (rx_rise && boot_rx_q == 2'h2) begin
          done_d = 1'b0;
          cur_d = ps_legal ? req_ps : PS_LINK_IDLE;
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (det_go) begin
          st_d = ST_DETECT;
          cnt_d = 16'(DETECT_CYCLES);
        end else if (move_go) begin
          st_d = ST_MOVE;
          tgt_d = req_ps;
          cnt_d = (req_ps == PS_LINK_IDLE) ? 16'(CM_SETTLE_CYCLES) : 16'(MOVE_CYCLES);
        end
      end
      ST_MOVE: begin
        if (cnt_q == 16'h0 && rx_rise) begin
          done_d = 1'b1;
          cur_d = tgt_ps_q;
          st_d = ST_RUN;
        end
      end
      default: begin
        if (cnt_q == 16'h0 && rx_rise) begin
          done_d = 1'b1;
          rxst_d = present_q ? RXST_PRESENT : RXST_NONE;
          st_d = ST_RUN;
        end
      end
    endcase
  end
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_q <= ST_BOOT;
      cnt_q <= 16'h0;
      done_q <= 1'b1;
      rxst_q <= RXST_NONE;
      cur_ps_q <= PS_LINK_IDLE;
      tgt_ps_q <= PS_LINK_IDLE;
      boot_rx_q <= 2'h0;
      det_seen_q <= 1'b0;
      present_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
      rxst_q <= rxst_d;
      cur_ps_q <= cur_d;
      tgt_ps_q <= tgt_d;
      if (rx_rise && boot_rx_q != 2'h2) boot_rx_q <= boot_rx_q + 2'h1;
      det_seen_q <= det_go | (det_seen_q & det_req);
      if (st_q == ST_DETECT) present_q <= I_FAR_RECEIVER_SENSE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data paths: scrambler per byte, tx on MAC clock edges, rx on own clock
  function automatic logic [23:0] scr_byte(input logic [15:0] s, input logic [7:0] d);
    logic [15:0] l;
    logic [7:0] o;
    l = s;
    o = 8'h0;
    for (int i = 0; i < 8; i++) begin
      o[i] = d[i] ^ l[15];
      l = {l[14:0], 1'b0} ^ (l[15] ? SCR_TAPS : 16'h0);
    end
    return {l, o};
  endfunction : scr_byte
  logic [15:0] tx_lfsr_q, rx_lfsr_q, tx_word_q, rx_word_q, rx_bus_q;
  logic [7:0] tx_low_q;
  logic tx_valid_q, saving_q;
  wire tx_live = (cur_ps_q == PS_FULL) & (st_q == ST_RUN) & ~tx_idle;
  wire rx_live = (cur_ps_q == PS_FULL) & (st_q == ST_RUN) & ~I_RX_LINE_IDLE;
  wire tx_word_ev = narrow ? tx_fall : tx_rise;
  wire [15:0] tx_word = narrow ? {tx_word_in[7:0], tx_low_q} : tx_word_in;
  wire [23:0] tx_s0 = scr_byte(tx_lfsr_q, tx_word[7:0]);
  wire [23:0] tx_s1 = scr_byte(tx_s0[23:8], tx_word[15:8]);
  wire [23:0] rx_s0 = scr_byte(rx_lfsr_q, I_RX_LINE_WORD[7:0]);
  wire [23:0] rx_s1 = scr_byte(rx_s0[23:8], I_RX_LINE_WORD[15:8]);
  wire [15:0] tx_enc = scr_en ? {tx_s1[7:0], tx_s0[7:0]} : tx_word;
  wire [15:0] rx_dec = scr_en ? {rx_s1[7:0], rx_s0[7:0]} : I_RX_LINE_WORD;
  wire save_d = I_RX_LINE_IDLE & (cur_ps_q == PS_FULL | cur_ps_q == PS_TX_STANDBY);
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      {tx_lfsr_q, rx_lfsr_q} <= {SCR_SEED, SCR_SEED};
      {tx_word_q, rx_word_q, rx_bus_q, tx_low_q} <= '0;
      tx_valid_q <= 1'b0;
      saving_q <= 1'b0;
    end else begin
      if (tx_rise) tx_low_q <= tx_word_in[7:0];
      tx_valid_q <= tx_word_ev & tx_live;
      if (tx_word_ev && tx_live) tx_word_q <= tx_enc;
      if (tx_word_ev && tx_live) tx_lfsr_q <= tx_s1[23:8];
      if (rx_rise && rx_live) rx_word_q <= rx_dec;
      if (rx_rise && rx_live) rx_lfsr_q <= rx_s1[23:8];
      if (rx_rise) rx_bus_q <= narrow ? {8'h0, rx_word_q[7:0]} : rx_word_q;
      else if (rx_fall && narrow) rx_bus_q <= {8'h0, rx_word_q[15:8]};
      saving_q <= save_d;
    end
  end

  assign status = '{detect_present: present_q, rx_saving: saving_q, rx_clk_stopped: rx_stop,
                    ref_125: ref_sel_q, busy: st_q != ST_RUN, power_state: cur_ps_q};
  assign {O_AWREADY, O_WREADY, O_BVALID, O_BRESP} = {awready_q, wready_q, bvalid_q, bresp_q};
  assign {O_ARREADY, O_RVALID, O_RDATA, O_RRESP} = {arready_q, rvalid_q, rdata_q, rresp_q};
  assign {O_RX_OUTPUT_CLOCK, O_RX_DATA_BUS, O_RX_STATUS, O_PHY_DONE} =
         {rx_clk_q, rx_bus_q, rxst_q, done_q};
  assign {O_TX_LINE_WORD, O_TX_LINE_VALID, O_RX_SAVING, O_REF_SEL_125} =
         {tx_word_q, tx_valid_q, saving_q, ref_sel_q};

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking ck @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  localparam int TOG_MAX = RX_HALF;
  localparam int SETTLE_MIN = CM_SETTLE_CYCLES;
  logic [15:0] hi_len_q, move_len_q;
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      hi_len_q <= 16'h0;
      move_len_q <= 16'h0;
    end else begin
      hi_len_q <= done_q ? hi_len_q + 16'h1 : 16'h0;
      move_len_q <= (st_q == ST_MOVE) ? move_len_q + 16'h1 : 16'h0;
    end
  end
  AST_DONE_ONE_RX_CYCLE: assert property ($fell(done_q) && $past(st_q) != ST_BOOT |->
    $past(hi_len_q) == 16'(2 * RX_HALF - 1)) else $error("done pulse width wrong");
  AST_RX_CLOCK_RUNS: assert property (!rx_stop |-> ##[0:TOG_MAX] $changed(rx_clk_q))
    else $error("rx clock stalled");
  AST_REF_SEL_HELD: assert property (caught_q && $past(caught_q) |-> $stable(ref_sel_q))
    else $error("clock select changed after reset");
  AST_DETECT_CODE: assert property (rxst_q != RXST_NONE |-> done_q && rxst_q == RXST_PRESENT)
    else $error("bad detect status");
  AST_TX_FULL_ONLY: assert property (tx_valid_q |-> $past(cur_ps_q) == PS_FULL)
    else $error("tx outside full power");
  AST_RX_SAVING: assert property (I_RX_LINE_IDLE && cur_ps_q == PS_FULL |=> saving_q)
    else $error("receiver not saving");
  AST_IDLE_SETTLE: assert property ($rose(done_q) && cur_ps_q == PS_LINK_IDLE &&
    $past(st_q) == ST_MOVE |-> $past(move_len_q) >= 16'(SETTLE_MIN)) else $error("early done");
  AST_BOOT_DONE: assert property (st_q == ST_BOOT |-> done_q) else $error("done low in boot");
  AST_NO_BAD_STATE: assert property (cur_ps_q != PS_UNSUPPORTED) else $error("bad state");
  AST_SLEEP_STOPS: assert property (rx_stop [*2] |-> $stable(rx_clk_q))
    else $error("rx clock runs in sleep");
endmodule : pcmc_top
`default_nettype wire

// ===== pcmc_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcmc_mac_model
  import pcmc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_narrow,
  input wire logic i_done,
  input wire logic [2:0] i_status,
  output logic [1:0] o_power_sel,
  output logic o_detect,
  output logic o_sleep,
  output logic o_tx_idle,
  output logic o_tx_clk,
  output logic [15:0] o_tx_data
);
  logic tx_run;
  initial begin
    tx_run = 1'b0;
    o_power_sel = PS_LINK_IDLE;
    o_detect = 1'b0;
    o_sleep = 1'b0;
    o_tx_idle = 1'b1;
    o_tx_clk = 1'b0;
    o_tx_data = 16'h0000;
    #137;
    // Stands low between bursts
    forever #200 o_tx_clk = tx_run ? ~o_tx_clk : 1'b0;
  end
  ////////////////////
  // Settle gap first, so a detect level never drops for a single cycle only
  task automatic request(input logic [1:0] sel, input logic det, output int lat,
    output int wid, output logic [2:0] st);
    repeat (4) @(posedge i_clk);
    o_power_sel <= sel;
    o_detect <= det;
    lat = 0;
    wid = 0;
    st = 3'h7;
    while (i_done !== 1'b1 && lat < 400) begin
      @(posedge i_clk);
      lat++;
    end
    if (i_done === 1'b1) st = i_status;
    while (i_done === 1'b1 && wid < 400) begin
      @(posedge i_clk);
      wid++;
    end
    o_detect <= 1'b0;
  endtask : request
  task automatic sleep(input logic v);
    @(posedge i_clk);
    o_sleep <= v;
  endtask : sleep
  ////////////////////
  task automatic send_words(input logic [15:0] first, input int n);
    logic [15:0] w;
    @(posedge i_clk);
    o_tx_idle <= 1'b0;
    repeat (4) @(posedge i_clk);
    tx_run = 1'b1;
    for (int k = 0; k < n; k++) begin
      w = first + 16'(k) * 16'h1111;
      @(posedge o_tx_clk);
      o_tx_data <= i_narrow ? {~w[7:0], w[7:0]} : w;
      @(negedge o_tx_clk);
      if (i_narrow) o_tx_data <= {~w[15:8], w[15:8]};
    end
    tx_run = 1'b0;
    // Disturb the pins only once the last byte has been sampled
    repeat (8) @(posedge i_clk);
    o_tx_data <= ~o_tx_data;
    o_tx_idle <= 1'b1;
  endtask : send_words
endmodule : pcmc_mac_model
`default_nettype wire

// ===== pcie_phy_mac_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pcie_phy_mac_control_tb;
  import pcmc_pkg::*;
  localparam int RXH = 2;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, narrow, clk_sel, line_idle, far_sense, done, rx_clk, saving;
  logic ref125, det, slp, tx_idle, tx_clk, tx_valid, rx_prev;
  logic [1:0] bresp, rresp, psel;
  logic [2:0] rx_status;
  logic [7:0] awaddr, araddr;
  logic [15:0] tx_data, line_word, rx_data, tx_word;
  logic [31:0] wdata, rdata;
  logic [15:0] txq[$];
  int fails, compares, rx_toggles;
  pcmc_top #(.RX_HALF(RXH)) pcmc_top_i (
    .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid),
    .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_POWER_STATE_SELECT(psel),
    .I_DETECT_OR_LOOPBACK(det), .I_DEEP_SLEEP_REQUEST(slp), .I_TX_ELECTRICAL_IDLE(tx_idle),
    .I_CLK_SEL(clk_sel), .I_NARROW_MODE(narrow), .I_TX_INPUT_CLOCK(tx_clk),
    .I_TX_DATA_BUS(tx_data), .I_RX_LINE_WORD(line_word), .I_RX_LINE_IDLE(line_idle),
    .I_FAR_RECEIVER_SENSE(far_sense), .O_RX_OUTPUT_CLOCK(rx_clk), .O_RX_DATA_BUS(rx_data),
    .O_RX_STATUS(rx_status), .O_PHY_DONE(done), .O_TX_LINE_WORD(tx_word),
    .O_TX_LINE_VALID(tx_valid), .O_RX_SAVING(saving), .O_REF_SEL_125(ref125)
  );
  pcmc_mac_model pcmc_mac_model_i (
    .i_clk(clk), .i_narrow(narrow), .i_done(done), .i_status(rx_status), .o_power_sel(psel),
    .o_detect(det), .o_sleep(slp), .o_tx_idle(tx_idle), .o_tx_clk(tx_clk), .o_tx_data(tx_data)
  );
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    rx_prev <= rx_clk;
    if (rx_clk !== rx_prev) rx_toggles++;
    if (tx_valid === 1'b1) txq.push_back(tx_word);
  end
  ////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic chk_min(input string nm, input int lo, input int g);
    compares++;
    if (g < lo) begin
      fails++;
      $display("wrong value %s expected at least %0d seen %0d", nm, lo, g);
    end
  endtask : chk_min
  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  ////////////////////
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr
  task automatic status(output pcmc_status_type s);
    logic [31:0] d;
    logic [1:0] r;
    axr(REG_STATUS_OFS, d, r);
    chk("status read resp", RESP_OKAY, r);
    s = pcmc_status_type'(d[6:0]);
  endtask : status
  ////////////////////
  task automatic reset_dut(input logic sel);
    int n;
    pcmc_status_type s;
    @(posedge clk);
    rst_n <= 1'b0;
    clk_sel <= sel;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    n = rx_toggles;
    @(posedge clk);
    clk_sel <= ~sel;
    for (int k = 0; k < 200 && done !== 1'b0; k++) @(posedge clk);
    chk_min("rx toggles before done low", 2, rx_toggles - n);
    status(s);
    chk("boot power state", PS_LINK_IDLE, s.power_state);
    chk("status clock select", sel, s.ref_125);
    chk("clock select pin", sel, ref125);
  endtask : reset_dut
  task automatic regs();
    logic [31:0] d;
    logic [1:0] r;
    axr(REG_CTRL_OFS, d, r);
    chk("ctrl reset value", CTRL_RESET, d);
    axw(8'h08, 32'hFFFFFFFF, r);
    chk("unmapped write resp", RESP_DECERR, r);
    axr(8'h0C, d, r);
    chk("unmapped read data", 32'h0, d);
    chk("unmapped read resp", RESP_DECERR, r);
  endtask : regs
  task automatic move(input logic [1:0] sel, input int lo, input int ew, input logic [1:0] es);
    int lat, wid, t;
    logic [2:0] st;
    pcmc_status_type s;
    pcmc_mac_model_i.request(sel, 1'b0, lat, wid, st);
    chk_min("move latency", lo, lat);
    chk("done width", ew, wid);
    status(s);
    chk("power state", es, s.power_state);
    t = rx_toggles;
    repeat (20) @(posedge clk);
    chk_min("rx clock runs", 5, rx_toggles - t);
  endtask : move
  task automatic detect(input logic sense);
    int lat, wid;
    logic [2:0] st;
    pcmc_status_type s;
    @(posedge clk);
    far_sense <= sense;
    pcmc_mac_model_i.request(PS_LINK_IDLE, 1'b1, lat, wid, st);
    chk_min("detect time", DETECT_CYCLES, lat);
    chk("detect done width", 2 * RXH, wid);
    chk("detect code", sense ? RXST_PRESENT : RXST_NONE, st);
    chk("code after done", RXST_NONE, rx_status);
    status(s);
    chk("detect flag", sense, s.detect_present);
  endtask : detect
  task automatic deep_sleep();
    int t;
    pcmc_status_type s;
    pcmc_mac_model_i.sleep(1'b1);
    repeat (8) @(posedge clk);
    t = rx_toggles;
    repeat (20) @(posedge clk);
    chk("rx clock stopped", t, rx_toggles);
    status(s);
    chk("stopped flag", 1, s.rx_clk_stopped);
    pcmc_mac_model_i.sleep(1'b0);
    repeat (8) @(posedge clk);
    t = rx_toggles;
    repeat (20) @(posedge clk);
    chk_min("rx clock resumed", 5, rx_toggles - t);
  endtask : deep_sleep
  task automatic tx_burst(input logic nar, input logic scr);
    logic [1:0] r;
    logic [15:0] w;
    axw(REG_CTRL_OFS, {31'h0, scr}, r);
    chk("ctrl write resp", RESP_OKAY, r);
    @(posedge clk);
    narrow <= nar;
    txq.delete();
    pcmc_mac_model_i.send_words(16'h1234, 4);
    chk("tx word count", 4, txq.size());
    for (int k = 0; k < 4 && k < txq.size(); k++) begin
      w = 16'h1234 + 16'(k) * 16'h1111;
      if (scr) chk("scrambled word", 1, txq[k] !== w);
      else chk("tx word", w, txq[k]);
    end
  endtask : tx_burst
  task automatic wait_rx(input logic lv);
    logic p;
    // Stop on the first sample of the new phase, away from the next launch
    p = lv;
    for (int n = 0; n < 50; n++) begin
      @(posedge clk);
      if (rx_clk === lv && p !== lv) break;
      p = rx_clk;
    end
  endtask : wait_rx
  task automatic rx_path();
    @(posedge clk);
    line_word <= 16'h3CA5;
    narrow <= 1'b0;
    repeat (12) @(posedge clk);
    chk("rx word wide", 16'h3CA5, rx_data);
    narrow <= 1'b1;
    repeat (12) @(posedge clk);
    wait_rx(1'b1);
    chk("rx low byte", 16'h00A5, rx_data);
    wait_rx(1'b0);
    chk("rx high byte", 16'h003C, rx_data);
    line_idle <= 1'b1;
    repeat (10) @(posedge clk);
    chk("rx saving on", 1, saving);
    line_idle <= 1'b0;
    repeat (10) @(posedge clk);
    chk("rx saving off", 0, saving);
  endtask : rx_path
  ////////////////////
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, narrow, line_idle, far_sense} = '0;
    {awaddr, araddr, wdata, line_word, rx_prev} = '0;
    clk_sel = 1'b1;
    fails = 0;
    compares = 0;
    rx_toggles = 0;
    reset_dut(1'b1);
    regs();
    move(PS_FULL, MOVE_CYCLES, 2 * RXH, PS_FULL);
    move(PS_UNSUPPORTED, 400, 0, PS_FULL);
    tx_burst(1'b0, 1'b0);
    tx_burst(1'b1, 1'b0);
    rx_path();
    tx_burst(1'b0, 1'b1);
    move(PS_TX_STANDBY, MOVE_CYCLES, 2 * RXH, PS_TX_STANDBY);
    move(PS_FULL, MOVE_CYCLES, 2 * RXH, PS_FULL);
    move(PS_LINK_IDLE, CM_SETTLE_CYCLES, 2 * RXH, PS_LINK_IDLE);
    detect(1'b1);
    detect(1'b0);
    deep_sleep();
    reset_dut(1'b0);
    stop_test();
  end
  initial begin
    #1000000;
    fails++;
    stop_test();
  end
endmodule : pcie_phy_mac_control_tb
`default_nettype wire
